/* File: design/dei_ctrl.sv */
/*
 * dei_ctrl: event and interrupt-enable control slice of a converter.
 * Holds the event control register, a buffer/data register pair, the
 * shared interrupt-enable flags seen through a set and a clear view,
 * sticky interrupt status and one level interrupt output.
 * Assumes an APB master on pclk and an event system giving level
 * events synchronous to pclk.
 */
// Summary of operation
// - drain-event enable set: pulse event output whenever buffer empties; clear: none
// - trigger-event enable set: incoming event moves a full buffer into data register while idle; otherwise underrun
// - writing one to clear-register bit 2 disables sync-ready interrupt enable
// - writing one to clear-register bit 1 disables buffer-empty interrupt enable
// - zero bits written to the clear register leave enables unchanged
// - set and clear registers read the same single enable flags
// - clear register reads one for enabled, zero for disabled interrupts
`timescale 1ns/100ps
module dei_ctrl (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        conv_event_in,
    output logic             drain_event_out,
    output logic [9:0]       conv_data_out,
    output logic             irq
);

    typedef struct packed {
        logic [7:0]                  evctrl;
        logic [dei_pkg::IRQ_W-1:0]   irq_en;
        logic [dei_pkg::IRQ_W-1:0]   irq_stat;
        logic [dei_pkg::DATA_W-1:0]  buf_data;
        logic                        buf_full;
        logic [dei_pkg::DATA_W-1:0]  conv_data;
        dei_pkg::dei_conv_t          conv_st;
        logic [3:0]                  conv_cnt;
        logic [1:0]                  sync_cnt;
        logic                        sync_busy;
        logic                        drain_ev;
        logic                        irq;
        logic [31:0]                 prdata;
        logic                        pready;
        logic                        pslverr;
    } dei_state_t;

    dei_state_t st_q;
    dei_state_t st_d;

    logic ev_strobe;

    // event arrives as a level; only its rising edge may trigger
    dei_pulse_edge u_edge (
        .pclk      (pclk),
        .presetn   (presetn),
        .level_in  (conv_event_in),
        .pulse_out (ev_strobe)
    );

    logic                       acc;
    logic                       wr;
    logic                       rd;
    logic                       trig;
    logic                       buf_load;
    logic [dei_pkg::IRQ_W-1:0]  ev_set;
    logic [dei_pkg::IRQ_W-1:0]  flag_clr;
    logic [31:0]                rdata;
    logic                       mapped;

    // one-wait-state slave: setup, access with pready low, then pready high
    assign acc = psel & penable & ~st_q.pready;
    assign wr  = acc & pwrite;
    assign rd  = acc & ~pwrite;

    // read mux and decode
    always_comb
    begin
        rdata  = 32'h0000_0000;
        mapped = 1'b1;
        case (paddr)
            dei_pkg::ADDR_EVCTRL:      rdata = {24'h00_0000, st_q.evctrl};
            dei_pkg::ADDR_IRQ_EN_CLR:  rdata = {29'h0, st_q.irq_en};
            dei_pkg::ADDR_IRQ_EN_SET:  rdata = {29'h0, st_q.irq_en};
            dei_pkg::ADDR_IRQ_STATUS:  rdata = {29'h0, st_q.irq_stat};
            dei_pkg::ADDR_IRQ_FLAG_CLR: rdata = 32'h0000_0000;
            dei_pkg::ADDR_BUF_DATA:    rdata = {22'h0, st_q.buf_data};
            dei_pkg::ADDR_CONV_DATA:   rdata = {22'h0, st_q.conv_data};
            dei_pkg::ADDR_SYNC_CMD:    rdata = {31'h0, st_q.sync_busy};
            default:                   mapped = 1'b0;
        endcase
    end

    // incoming event only converts when enabled and a code is waiting
    assign trig = ev_strobe & st_q.evctrl[dei_pkg::EV_TRIG_IN_BIT];
    assign buf_load = wr & (paddr == dei_pkg::ADDR_BUF_DATA);

    always_comb
    begin
        st_d          = st_q;
        ev_set        = '0;
        flag_clr      = '0;
        st_d.drain_ev = 1'b0;
        st_d.pready   = acc;
        st_d.pslverr  = acc & ~mapped;
        st_d.prdata   = rd ? rdata : 32'h0000_0000;

        // conversion: buffer moves to data register, buffer becomes empty
        case (st_q.conv_st)
            dei_pkg::DEI_IDLE:
            begin
                if (trig && st_q.buf_full)
                begin
                    st_d.conv_data = st_q.buf_data;
                    st_d.buf_full  = 1'b0;
                    st_d.conv_cnt  = dei_pkg::CONV_CNT_LOAD;
                    st_d.conv_st   = dei_pkg::DEI_CONV;
                    st_d.drain_ev  = st_q.evctrl[dei_pkg::EV_DRAIN_OUT_BIT];
                    ev_set[dei_pkg::IRQ_EMPTY_BIT] = 1'b1;
                end
                else if (trig)
                    ev_set[dei_pkg::IRQ_UNDERRUN_BIT] = 1'b1; // nothing to convert
            end
            dei_pkg::DEI_CONV:
            begin
                // a trigger while the core is still settling is an underrun
                if (trig)
                    ev_set[dei_pkg::IRQ_UNDERRUN_BIT] = 1'b1;
                if (st_q.conv_cnt == 4'h0)
                    st_d.conv_st = dei_pkg::DEI_IDLE;
                else
                    st_d.conv_cnt = st_q.conv_cnt - 4'h1;
            end
            default: st_d.conv_st = dei_pkg::DEI_IDLE;
        endcase

        // sync countdown models a register write crossing to the core
        if (st_q.sync_busy)
        begin
            if (st_q.sync_cnt == 2'h0)
            begin
                st_d.sync_busy = 1'b0;
                ev_set[dei_pkg::IRQ_SYNC_BIT] = 1'b1;
            end
            else
                st_d.sync_cnt = st_q.sync_cnt - 2'h1;
        end

        if (wr)
        begin
            case (paddr)
                dei_pkg::ADDR_EVCTRL:
                    st_d.evctrl = {6'h00, pwdata[1:0]};
                // one bits clear, zero bits keep; shared flag
                dei_pkg::ADDR_IRQ_EN_CLR:
                    st_d.irq_en = st_q.irq_en & ~pwdata[dei_pkg::IRQ_W-1:0];
                dei_pkg::ADDR_IRQ_EN_SET:
                    st_d.irq_en = st_q.irq_en | pwdata[dei_pkg::IRQ_W-1:0];
                dei_pkg::ADDR_IRQ_FLAG_CLR:
                    flag_clr = pwdata[dei_pkg::IRQ_W-1:0];
                dei_pkg::ADDR_SYNC_CMD:
                begin
                    if (pwdata[0])
                    begin
                        st_d.sync_busy = 1'b1;
                        st_d.sync_cnt  = dei_pkg::SYNC_CNT_LOAD;
                    end
                end
                default: ;
            endcase
        end

        // software refills the buffer; a write in a convert cycle wins
        if (buf_load)
        begin
            st_d.buf_data = pwdata[dei_pkg::DATA_W-1:0];
            st_d.buf_full = 1'b1;
        end

        // set wins over clear for sticky status
        st_d.irq_stat = (st_q.irq_stat & ~flag_clr) | ev_set;
        st_d.irq = |(st_d.irq_stat & st_d.irq_en);
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_q           <= '0;
            st_q.evctrl    <= dei_pkg::EVCTRL_RST;
            st_q.irq_en    <= dei_pkg::IRQ_EN_RST;
            st_q.conv_st   <= dei_pkg::DEI_IDLE;
        end
        else
            st_q <= st_d;
    end

    assign prdata          = st_q.prdata;
    assign pready          = st_q.pready;
    assign pslverr         = st_q.pslverr;
    assign drain_event_out = st_q.drain_ev;
    assign conv_data_out   = st_q.conv_data;
    assign irq             = st_q.irq;

endmodule

/* File: design/dei_pkg.sv */
/*
 * dei_pkg: register map, field positions, reset values and state encodings
 * for the converter event and interrupt-enable control block.
 * Assumes a 32-bit APB slave with word-aligned registers.
 */
package dei_pkg;

    // register byte offsets
    localparam logic [7:0] ADDR_EVCTRL      = 8'h00;
    localparam logic [7:0] ADDR_IRQ_EN_CLR  = 8'h04;
    localparam logic [7:0] ADDR_IRQ_EN_SET  = 8'h08;
    localparam logic [7:0] ADDR_IRQ_STATUS  = 8'h0c;
    localparam logic [7:0] ADDR_IRQ_FLAG_CLR = 8'h10;
    localparam logic [7:0] ADDR_BUF_DATA    = 8'h14;
    localparam logic [7:0] ADDR_CONV_DATA   = 8'h18;
    localparam logic [7:0] ADDR_SYNC_CMD    = 8'h1c;

    // event control fields
    localparam int EV_TRIG_IN_BIT  = 0;
    localparam int EV_DRAIN_OUT_BIT = 1;

    // interrupt fields (enable, status and clear share this layout)
    localparam int IRQ_UNDERRUN_BIT = 0;
    localparam int IRQ_EMPTY_BIT    = 1;
    localparam int IRQ_SYNC_BIT     = 2;
    localparam int IRQ_W            = 3;

    localparam logic [7:0]       EVCTRL_RST  = 8'h00;
    localparam logic [IRQ_W-1:0] IRQ_EN_RST  = 3'h0;
    localparam int               DATA_W      = 10;

    // time the converter core needs to accept a new code
    localparam int CONV_TIME_NS   = 100;
    localparam int CLK_PERIOD_NS  = 10;
    localparam int CONV_CYCLES    = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0] CONV_CNT_LOAD = 4'(CONV_CYCLES - 1);

    // sync delay before the sync-ready flag rises
    localparam logic [1:0] SYNC_CNT_LOAD = 2'h3;

    typedef enum logic [1:0] {
        DEI_IDLE = 2'b00,
        DEI_CONV = 2'b01
    } dei_conv_t;

endpackage

/* File: design/dei_pulse_edge.sv */
/*
 * dei_pulse_edge: rising-edge detector turning an event level into
 * a one-cycle strobe. Assumes the input is synchronous to pclk.
 */
`timescale 1ns/100ps
module dei_pulse_edge (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic level_in,
    output logic      pulse_out
);

    typedef struct packed {
        logic prev;
    } dei_edge_t;

    dei_edge_t st_q;
    dei_edge_t st_d;

    // remember last level; strobe on 0->1 only
    always_comb
    begin
        st_d      = st_q;
        st_d.prev = level_in;
    end

    assign pulse_out = level_in & ~st_q.prev;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            st_q <= '0;
        else
            st_q <= st_d;
    end

endmodule

/* File: dv/dei_ctrl_props.sv */
/* dei_ctrl_props: port-level checks of the control block.
   Assumes one pclk domain; bound to every dei_ctrl instance. */
`timescale 1ns/100ps
module dei_ctrl_chk (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        conv_event_in,
    input wire logic        drain_event_out,
    input wire logic [9:0]  conv_data_out,
    input wire logic        irq
);
    default clocking dc @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // bus answer: one wait state, one-cycle ready, error only off the map
    a_ready_wait: assert property (psel && penable && !pready |=> pready)
        else $error("ready missing after access edge");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready held too long");
    a_err_map: assert property (pready
        |-> pslverr == (paddr[1:0] != 2'h0 || paddr > 8'h1c))
        else $error("error response wrong for address");
    a_rdata_idle: assert property (!(pready && !pwrite) |-> prdata == 32'h0)
        else $error("read data outside read answer");
    a_clr_read: assert property (pready && !pwrite && paddr == dei_pkg::ADDR_IRQ_EN_CLR
        |-> prdata[31:3] == 29'h0)
        else $error("enable view shows unused bits");
    // events: drain strobe and new code only one edge after a trigger edge
    a_drain_once: assert property (drain_event_out |=> !drain_event_out)
        else $error("drain event longer than one cycle");
    a_drain_cause: assert property (drain_event_out
        |-> $past(conv_event_in) && !$past(conv_event_in, 2))
        else $error("drain event without trigger edge");
    a_data_cause: assert property ($changed(conv_data_out)
        |-> $past(conv_event_in) && !$past(conv_event_in, 2))
        else $error("data register moved without trigger edge");
    a_irq_off: assert property (pready && pwrite && paddr == dei_pkg::ADDR_IRQ_EN_CLR
        && pwdata[2:0] == 3'h7 |=> !irq)
        else $error("irq stays up with all enables cleared");
endmodule

bind dei_ctrl dei_ctrl_chk i_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .conv_event_in, .drain_event_out,
    .conv_data_out, .irq);

/* File: dv/dei_ctrl_tb_top.sv */
/* dei_ctrl_tb_top: directed scenarios over APB and the event model.
   Assumes the one-wait-state slave and event latency of the design. */
`timescale 1ns/100ps
module dei_ctrl_tb_top;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd_q;
    logic        pready, pslverr, err_q, conv_event_in, drain_event_out, irq;
    logic [9:0]  conv_data_out;
    int          error_cnt = 0;
    int          cmp_count = 0;
    int          drains;

    always #5 pclk = ~pclk;

    dei_ctrl i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .conv_event_in, .drain_event_out, .conv_data_out, .irq);
    dei_ev_src i_ev (.pclk, .presetn, .drain_event_out, .conv_event_in,
        .drain_cnt(drains));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // request held until ready is sampled high at a rising edge, then released
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 50)
        begin
            @(posedge pclk);
            n++;
        end
        if (pready !== 1'b1)
        begin
            error_cnt++;
            $display("FAIL t=%0t pready got=%h exp=%h", $time, pready, 1'b1);
        end
        rd_q = prdata;
        err_q = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd_q, e);
    endtask

    // one trigger, then wait past the conversion time before looking
    task automatic fire(input int hold);
        i_ev.pulse(hold);
        repeat (12) @(negedge pclk);
    endtask

    task automatic irq_bit(input int b);
        wr(dei_pkg::ADDR_IRQ_EN_SET, 32'h1 << b);
        @(negedge pclk);
        chk(32'(irq), 32'h1);
        wr(dei_pkg::ADDR_IRQ_EN_CLR, 32'h1 << b);
        @(negedge pclk);
        chk(32'(irq), 32'h0);
        wr(dei_pkg::ADDR_IRQ_FLAG_CLR, 32'h7);
    endtask

    task automatic t_reset();
        rd(dei_pkg::ADDR_EVCTRL, 32'h0);
        rd(dei_pkg::ADDR_IRQ_EN_CLR, 32'h0);
        rd(dei_pkg::ADDR_IRQ_EN_SET, 32'h0);
        $display("test reset done");
    endtask

    task automatic t_clear();
        wr(dei_pkg::ADDR_IRQ_EN_SET, 32'h7);
        rd(dei_pkg::ADDR_IRQ_EN_CLR, 32'h7);
        wr(dei_pkg::ADDR_IRQ_EN_CLR, 32'h4);
        rd(dei_pkg::ADDR_IRQ_EN_SET, 32'h3);
        wr(dei_pkg::ADDR_IRQ_EN_CLR, 32'h0);
        rd(dei_pkg::ADDR_IRQ_EN_CLR, 32'h3);
        wr(dei_pkg::ADDR_IRQ_EN_CLR, 32'h2);
        rd(dei_pkg::ADDR_IRQ_EN_SET, 32'h1);
        wr(dei_pkg::ADDR_IRQ_EN_CLR, 32'h7);
        rd(dei_pkg::ADDR_IRQ_EN_CLR, 32'h0);
        $display("test clear done");
    endtask

    task automatic t_event();
        wr(dei_pkg::ADDR_EVCTRL, 32'h3);
        wr(dei_pkg::ADDR_BUF_DATA, 32'h2a5);
        fire(1);
        chk(32'(conv_data_out), 32'h2a5);
        chk(32'(drains), 32'h1);
        wr(dei_pkg::ADDR_EVCTRL, 32'h1);
        wr(dei_pkg::ADDR_BUF_DATA, 32'h155);
        fire(3);
        chk(32'(conv_data_out), 32'h155);
        chk(32'(drains), 32'h1);
        wr(dei_pkg::ADDR_EVCTRL, 32'h0);
        wr(dei_pkg::ADDR_BUF_DATA, 32'h0f0);
        rd(dei_pkg::ADDR_BUF_DATA, 32'h0f0);
        fire(1);
        chk(32'(conv_data_out), 32'h155);
        $display("test event done");
    endtask

    task automatic t_irq();
        irq_bit(1);
        wr(dei_pkg::ADDR_EVCTRL, 32'h1);
        fire(1);
        chk(32'(conv_data_out), 32'h0f0);
        fire(1);
        rd(dei_pkg::ADDR_IRQ_STATUS, 32'h3);
        rd(dei_pkg::ADDR_CONV_DATA, 32'h0f0);
        irq_bit(0);
        wr(dei_pkg::ADDR_SYNC_CMD, 32'h1);
        rd(dei_pkg::ADDR_SYNC_CMD, 32'h1);
        repeat (8) @(negedge pclk);
        rd(dei_pkg::ADDR_SYNC_CMD, 32'h0);
        irq_bit(2);
        apb(1'b0, 8'h20, 32'h0);
        chk(32'(err_q), 32'h1);
        $display("test irq done");
    endtask

    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    initial
    begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_clear();
        t_event();
        t_irq();
        end_sim();
    end

    // about forty times the expected run, so only a real hang gets here
    initial
    begin
        #100000;
        error_cnt++;
        end_sim();
    end
endmodule

/* File: dv/dei_ev_src.sv */
/* dei_ev_src: event-system model giving trigger edges, counting drain events.
   Assumes events synchronous to pclk. */
`timescale 1ns/100ps
module dei_ev_src (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic drain_event_out,
    output logic      conv_event_in,
    output int        drain_cnt
);
    initial conv_event_in = 1'b0;

    // drain strobes are one cycle, so a plain count sees each once
    always @(posedge pclk or negedge presetn)
        if (!presetn)
            drain_cnt <= 0;
        else if (drain_event_out)
            drain_cnt <= drain_cnt + 1;

    // only the rising edge counts, so hold lets slow sources be mimicked
    task automatic pulse(input int hold);
        @(posedge pclk);
        conv_event_in <= 1'b1;
        repeat (hold) @(posedge pclk);
        conv_event_in <= 1'b0;
    endtask
endmodule
